// ===== pkg/mrd_pkg.sv
// Package: register offsets, structs and constants of the module register window
`default_nettype none
package mrd_pkg;
  localparam int         WIN_BYTES   = 256;
  localparam logic [7:0] OFF_A_IN    = 8'h00;
  localparam logic [7:0] OFF_B_IN    = 8'h01;
  localparam logic [7:0] OFF_A_MODE  = 8'h02;
  localparam logic [7:0] OFF_B_MODE  = 8'h03;
  localparam logic [7:0] OFF_A_OUT   = 8'h04;
  localparam logic [7:0] OFF_B_OUT   = 8'h05;
  localparam logic [7:0] OFF_A_DIR   = 8'h06;
  localparam logic [7:0] OFF_B_DIR   = 8'h07;
  localparam logic [7:0] OFF_A_DRV   = 8'h08;
  localparam logic [7:0] OFF_B_DRV   = 8'h09;
  localparam logic [7:0] OFF_A_IMC   = 8'h0A;
  localparam logic [7:0] OFF_B_IMC   = 8'h0B;
  localparam logic [7:0] OFF_A_OE    = 8'h0C;
  localparam logic [7:0] OFF_B_OE    = 8'h0D;
  localparam logic [7:0] OFF_C_IN    = 8'h10;
  localparam logic [7:0] OFF_D_IN    = 8'h11;
  localparam logic [7:0] OFF_C_OUT   = 8'h12;
  localparam logic [7:0] OFF_D_OUT   = 8'h13;
  localparam logic [7:0] OFF_C_DIR   = 8'h14;
  localparam logic [7:0] OFF_D_DIR   = 8'h15;
  localparam logic [7:0] OFF_C_DRV   = 8'h16;
  localparam logic [7:0] OFF_D_DRV   = 8'h17;
  localparam logic [7:0] OFF_C_IMC   = 8'h18;
  localparam logic [7:0] OFF_C_OE    = 8'h1A;
  localparam logic [7:0] OFF_D_OE    = 8'h1B;
  localparam logic [7:0] OFF_OMC_AB  = 8'h20;
  localparam logic [7:0] OFF_OMC_BC  = 8'h21;
  localparam logic [7:0] OFF_MSK_AB  = 8'h22;
  localparam logic [7:0] OFF_MSK_BC  = 8'h23;
  localparam logic [7:0] OFF_PWR0    = 8'hB0;
  localparam logic [7:0] OFF_PWR2    = 8'hB4;
  localparam logic [7:0] OFF_MAIN_LK = 8'hC0;
  localparam logic [7:0] OFF_BOOT_LK = 8'hC2;
  localparam logic [7:0] OFF_PAGE    = 8'hE0;
  localparam logic [7:0] OFF_MAP     = 8'hE2;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] ONES_BYTE   = 8'hFF;
  localparam int         NPORT       = 4;
  localparam int         PORT_A      = 0;
  localparam int         PORT_B      = 1;
  localparam int         PORT_C      = 2;
  localparam int         PORT_D      = 3;
  localparam int         MODE_PORTS  = 2;

  // Per-port pin configuration handed to the pin logic
  typedef struct packed {
    logic [7:0] out_value;
    logic [7:0] direction;
    logic [7:0] drive_type;
  } mrd_port_cfg_t;

  // One processor bus cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mrd_bus_t;
endpackage : mrd_pkg
`default_nettype wire

// ===== design/mrd_sync.sv
// Three-stage pin input synchroniser with change acceptance on agreement
`default_nettype none
module mrd_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] s1_next, s2_next, s3_next, q_next;

  always_comb
  begin
    s1_next = d;
    s2_next = s1_reg;
    s3_next = s2_reg;
    q_next  = q_reg;
    // Take the level only once stages two and three agree
    for (int i = 0; i < W; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        q_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end
    else if (ce)
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule : mrd_sync
`default_nettype wire

// ===== design/mrd_regs.sv
// Module register window decoder: port, macrocell, protection, power and mapping registers
`default_nettype none
module mrd_regs #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // Clock, reset, enable
  input  wire logic                        CLOCK,
  input  wire logic                        NRST,
  input  wire logic                        CE,
  // Processor bus and window base
  input  wire mrd_pkg::mrd_bus_t           BUS,
  input  wire logic [AW-1:0]               WIN_BASE,
  input  wire logic                        WIN_SELECT,
  output logic      [DW-1:0]               RDATA,
  output logic                             RVALID,
  // Pins and macrocells
  input  wire logic [mrd_pkg::NPORT*DW-1:0] PIN_IN,
  input  wire logic [mrd_pkg::NPORT*DW-1:0] DRIVER_EN,
  input  wire logic [3*DW-1:0]             IMC_IN,
  input  wire logic [2*DW-1:0]             OMC_IN,
  output logic      [2*DW-1:0]             OMC_LOAD,
  output logic      [2*DW-1:0]             OMC_DATA,
  output mrd_pkg::mrd_port_cfg_t [mrd_pkg::NPORT-1:0] PORT_CFG,
  output logic      [mrd_pkg::MODE_PORTS*DW-1:0]   PORT_MODE,
  // Flash protection, power, paging, mapping
  input  wire logic [DW-1:0]               MAIN_LOCK,
  input  wire logic [DW-1:0]               BOOT_LOCK,
  output logic      [DW-1:0]               PWR_FIRST,
  output logic      [DW-1:0]               PWR_SECOND,
  output logic      [DW-1:0]               PAGE,
  output logic      [DW-1:0]               SPACE_MAP,
  // Programming path
  input  wire logic                        TEST_PORT_ACTIVE,
  input  wire logic                        PROC_FLASH_REQ,
  input  wire logic                        PROC_ARRAY_REQ,
  output logic                             FLASH_PROG_GRANT,
  output logic                             ARRAY_PROG_GRANT
);
  localparam int NP = mrd_pkg::NPORT;

  // Pin-side inputs come from outside the bus domain
  logic [NP*DW-1:0] pin_s, den_s;
  logic [3*DW-1:0]  imc_s;
  logic [2*DW-1:0]  omc_s;
  logic [2*DW-1:0]  lock_s;

  mrd_sync #(.W(NP*DW)) u_pin (.clk(CLOCK), .nrst(NRST), .ce(CE), .d(PIN_IN), .q(pin_s));
  mrd_sync #(.W(NP*DW)) u_den (.clk(CLOCK), .nrst(NRST), .ce(CE), .d(DRIVER_EN), .q(den_s));
  mrd_sync #(.W(3*DW))  u_imc (.clk(CLOCK), .nrst(NRST), .ce(CE), .d(IMC_IN), .q(imc_s));
  mrd_sync #(.W(2*DW))  u_omc (.clk(CLOCK), .nrst(NRST), .ce(CE), .d(OMC_IN), .q(omc_s));
  mrd_sync #(.W(2*DW))  u_lck (.clk(CLOCK), .nrst(NRST), .ce(CE), .d({BOOT_LOCK, MAIN_LOCK}),
                               .q(lock_s));

  // Register state
  logic [DW-1:0] out_reg  [NP], out_next  [NP];
  logic [DW-1:0] dir_reg  [NP], dir_next  [NP];
  logic [DW-1:0] drv_reg  [NP], drv_next  [NP];
  logic [DW-1:0] mode_reg [2],  mode_next [2];
  logic [DW-1:0] msk_ab_reg, msk_ab_next, msk_bc_reg, msk_bc_next;
  logic [DW-1:0] pwr0_reg, pwr0_next, pwr2_reg, pwr2_next;
  logic [DW-1:0] page_reg, page_next, map_reg, map_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic          rvalid_reg, rvalid_next;
  logic [2*DW-1:0] load_reg, load_next, odat_reg, odat_next;
  logic          fgrant_reg, fgrant_next, agrant_reg, agrant_next;

  logic [AW-1:0] rel;
  logic [7:0]    off;
  logic          hit, wr, rd;

  always_comb
  begin
    rel = BUS.addr - WIN_BASE;
    off = rel[7:0];
    hit = WIN_SELECT && (rel < AW'(mrd_pkg::WIN_BYTES));
    wr  = hit && BUS.wr;
    rd  = hit && BUS.rd;
  end

  // Register writes; macrocell loads pulse for one cycle
  always_comb
  begin
    out_next    = out_reg;
    dir_next    = dir_reg;
    drv_next    = drv_reg;
    mode_next   = mode_reg;
    msk_ab_next = msk_ab_reg;
    msk_bc_next = msk_bc_reg;
    pwr0_next   = pwr0_reg;
    pwr2_next   = pwr2_reg;
    page_next   = page_reg;
    map_next    = map_reg;
    load_next   = '0;
    odat_next   = odat_reg;
    if (wr)
    begin
      if (off == mrd_pkg::OFF_A_MODE) mode_next[mrd_pkg::PORT_A] = BUS.wdata;
      else if (off == mrd_pkg::OFF_B_MODE) mode_next[mrd_pkg::PORT_B] = BUS.wdata;
      else if (off == mrd_pkg::OFF_A_OUT) out_next[mrd_pkg::PORT_A] = BUS.wdata;
      else if (off == mrd_pkg::OFF_B_OUT) out_next[mrd_pkg::PORT_B] = BUS.wdata;
      else if (off == mrd_pkg::OFF_C_OUT) out_next[mrd_pkg::PORT_C] = BUS.wdata;
      else if (off == mrd_pkg::OFF_D_OUT) out_next[mrd_pkg::PORT_D] = BUS.wdata;
      else if (off == mrd_pkg::OFF_A_DIR) dir_next[mrd_pkg::PORT_A] = BUS.wdata;
      else if (off == mrd_pkg::OFF_B_DIR) dir_next[mrd_pkg::PORT_B] = BUS.wdata;
      else if (off == mrd_pkg::OFF_C_DIR) dir_next[mrd_pkg::PORT_C] = BUS.wdata;
      else if (off == mrd_pkg::OFF_D_DIR) dir_next[mrd_pkg::PORT_D] = BUS.wdata;
      else if (off == mrd_pkg::OFF_A_DRV) drv_next[mrd_pkg::PORT_A] = BUS.wdata;
      else if (off == mrd_pkg::OFF_B_DRV) drv_next[mrd_pkg::PORT_B] = BUS.wdata;
      else if (off == mrd_pkg::OFF_C_DRV) drv_next[mrd_pkg::PORT_C] = BUS.wdata;
      else if (off == mrd_pkg::OFF_D_DRV) drv_next[mrd_pkg::PORT_D] = BUS.wdata;
      else if (off == mrd_pkg::OFF_OMC_AB)
      begin
        load_next[DW-1:0] = ~msk_ab_reg;
        odat_next[DW-1:0] = BUS.wdata;
      end
      else if (off == mrd_pkg::OFF_OMC_BC)
      begin
        load_next[2*DW-1:DW] = ~msk_bc_reg;
        odat_next[2*DW-1:DW] = BUS.wdata;
      end
      else if (off == mrd_pkg::OFF_MSK_AB) msk_ab_next = BUS.wdata;
      else if (off == mrd_pkg::OFF_MSK_BC) msk_bc_next = BUS.wdata;
      else if (off == mrd_pkg::OFF_PWR0) pwr0_next = BUS.wdata;
      else if (off == mrd_pkg::OFF_PWR2) pwr2_next = BUS.wdata;
      else if (off == mrd_pkg::OFF_PAGE) page_next = BUS.wdata;
      else if (off == mrd_pkg::OFF_MAP) map_next = BUS.wdata;
      // Writes to read-only and unused offsets fall through untouched
    end
  end

  // Read data, registered one cycle after the strobe
  always_comb
  begin
    rdata_next  = rdata_reg;
    rvalid_next = rd;
    if (rd)
    begin
      if (off == mrd_pkg::OFF_A_IN) rdata_next = pin_s[0*DW +: DW];
      else if (off == mrd_pkg::OFF_B_IN) rdata_next = pin_s[1*DW +: DW];
      else if (off == mrd_pkg::OFF_C_IN) rdata_next = pin_s[2*DW +: DW];
      else if (off == mrd_pkg::OFF_D_IN) rdata_next = pin_s[3*DW +: DW];
      else if (off == mrd_pkg::OFF_A_MODE) rdata_next = mode_reg[mrd_pkg::PORT_A];
      else if (off == mrd_pkg::OFF_B_MODE) rdata_next = mode_reg[mrd_pkg::PORT_B];
      else if (off == mrd_pkg::OFF_A_OUT) rdata_next = out_reg[mrd_pkg::PORT_A];
      else if (off == mrd_pkg::OFF_B_OUT) rdata_next = out_reg[mrd_pkg::PORT_B];
      else if (off == mrd_pkg::OFF_C_OUT) rdata_next = out_reg[mrd_pkg::PORT_C];
      else if (off == mrd_pkg::OFF_D_OUT) rdata_next = out_reg[mrd_pkg::PORT_D];
      else if (off == mrd_pkg::OFF_A_DIR) rdata_next = dir_reg[mrd_pkg::PORT_A];
      else if (off == mrd_pkg::OFF_B_DIR) rdata_next = dir_reg[mrd_pkg::PORT_B];
      else if (off == mrd_pkg::OFF_C_DIR) rdata_next = dir_reg[mrd_pkg::PORT_C];
      else if (off == mrd_pkg::OFF_D_DIR) rdata_next = dir_reg[mrd_pkg::PORT_D];
      else if (off == mrd_pkg::OFF_A_DRV) rdata_next = drv_reg[mrd_pkg::PORT_A];
      else if (off == mrd_pkg::OFF_B_DRV) rdata_next = drv_reg[mrd_pkg::PORT_B];
      else if (off == mrd_pkg::OFF_C_DRV) rdata_next = drv_reg[mrd_pkg::PORT_C];
      else if (off == mrd_pkg::OFF_D_DRV) rdata_next = drv_reg[mrd_pkg::PORT_D];
      else if (off == mrd_pkg::OFF_A_IMC) rdata_next = imc_s[0*DW +: DW];
      else if (off == mrd_pkg::OFF_B_IMC) rdata_next = imc_s[1*DW +: DW];
      else if (off == mrd_pkg::OFF_C_IMC) rdata_next = imc_s[2*DW +: DW];
      else if (off == mrd_pkg::OFF_A_OE) rdata_next = den_s[0*DW +: DW];
      else if (off == mrd_pkg::OFF_B_OE) rdata_next = den_s[1*DW +: DW];
      else if (off == mrd_pkg::OFF_C_OE) rdata_next = den_s[2*DW +: DW];
      else if (off == mrd_pkg::OFF_D_OE) rdata_next = den_s[3*DW +: DW];
      else if (off == mrd_pkg::OFF_OMC_AB) rdata_next = omc_s[DW-1:0];
      else if (off == mrd_pkg::OFF_OMC_BC) rdata_next = omc_s[2*DW-1:DW];
      else if (off == mrd_pkg::OFF_MSK_AB) rdata_next = msk_ab_reg;
      else if (off == mrd_pkg::OFF_MSK_BC) rdata_next = msk_bc_reg;
      else if (off == mrd_pkg::OFF_PWR0) rdata_next = pwr0_reg;
      else if (off == mrd_pkg::OFF_PWR2) rdata_next = pwr2_reg;
      else if (off == mrd_pkg::OFF_MAIN_LK) rdata_next = lock_s[DW-1:0];
      else if (off == mrd_pkg::OFF_BOOT_LK) rdata_next = lock_s[2*DW-1:DW];
      else if (off == mrd_pkg::OFF_PAGE) rdata_next = page_reg;
      else if (off == mrd_pkg::OFF_MAP) rdata_next = map_reg;
      else rdata_next = mrd_pkg::RST_BYTE;
    end
  end

  // Programming path arbitration; the test port always wins the flash path, and the processor never gets the array grant
  always_comb
  begin
    fgrant_next = PROC_FLASH_REQ && !TEST_PORT_ACTIVE;
    agrant_next = 1'b0;
    if (PROC_ARRAY_REQ)
    begin
      agrant_next = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < NP; i++)
      begin
        out_reg[i] <= mrd_pkg::RST_BYTE;
        dir_reg[i] <= mrd_pkg::RST_BYTE;
        drv_reg[i] <= mrd_pkg::RST_BYTE;
      end
      mode_reg[0] <= mrd_pkg::RST_BYTE;
      mode_reg[1] <= mrd_pkg::RST_BYTE;
      msk_ab_reg  <= mrd_pkg::RST_BYTE;
      msk_bc_reg  <= mrd_pkg::RST_BYTE;
      pwr0_reg    <= mrd_pkg::RST_BYTE;
      pwr2_reg    <= mrd_pkg::RST_BYTE;
      page_reg    <= mrd_pkg::RST_BYTE;
      map_reg     <= mrd_pkg::RST_BYTE;
      rdata_reg   <= mrd_pkg::RST_BYTE;
      rvalid_reg  <= 1'b0;
      load_reg    <= '0;
      odat_reg    <= '0;
      fgrant_reg  <= 1'b0;
      agrant_reg  <= 1'b0;
    end
    else if (CE)
    begin
      out_reg     <= out_next;
      dir_reg     <= dir_next;
      drv_reg     <= drv_next;
      mode_reg    <= mode_next;
      msk_ab_reg  <= msk_ab_next;
      msk_bc_reg  <= msk_bc_next;
      pwr0_reg    <= pwr0_next;
      pwr2_reg    <= pwr2_next;
      page_reg    <= page_next;
      map_reg     <= map_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      load_reg    <= load_next;
      odat_reg    <= odat_next;
      fgrant_reg  <= fgrant_next;
      agrant_reg  <= agrant_next;
    end
  end

  // Outputs straight from flip-flops
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_cfg
      assign PORT_CFG[g].out_value  = out_reg[g];
      assign PORT_CFG[g].direction  = dir_reg[g];
      assign PORT_CFG[g].drive_type = drv_reg[g];
    end
  endgenerate

  assign PORT_MODE        = {mode_reg[1], mode_reg[0]};
  assign RDATA            = rdata_reg;
  assign RVALID           = rvalid_reg;
  assign OMC_LOAD         = load_reg;
  assign OMC_DATA         = odat_reg;
  assign PWR_FIRST        = pwr0_reg;
  assign PWR_SECOND       = pwr2_reg;
  assign PAGE             = page_reg;
  assign SPACE_MAP        = map_reg;
  assign FLASH_PROG_GRANT = fgrant_reg;
  assign ARRAY_PROG_GRANT = agrant_reg;
endmodule : mrd_regs
`default_nettype wire

// ===== tb/mrd_regs_props.sv
// Checker: bus answer timing, register loads, cell loads tied to their writes, and grants
`default_nettype none
module mrd_regs_props #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic                                        CLOCK,
  input wire logic                                        NRST,
  // Bus side
  input wire logic                                        CE,
  input wire mrd_pkg::mrd_bus_t                           BUS,
  input wire logic [AW-1:0]                               WIN_BASE,
  input wire logic                                        WIN_SELECT,
  input wire logic [DW-1:0]                               RDATA,
  input wire logic                                        RVALID,
  // Register outputs
  input wire logic [2*DW-1:0]                             OMC_LOAD,
  input wire logic [2*DW-1:0]                             OMC_DATA,
  input wire mrd_pkg::mrd_port_cfg_t [mrd_pkg::NPORT-1:0] PORT_CFG,
  input wire logic [DW-1:0]                               SPACE_MAP,
  // Programming path
  input wire logic                                        TEST_PORT_ACTIVE,
  input wire logic                                        PROC_FLASH_REQ,
  input wire logic                                        PROC_ARRAY_REQ,
  input wire logic                                        FLASH_PROG_GRANT,
  input wire logic                                        ARRAY_PROG_GRANT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [AW-1:0] rel;
  logic [7:0]    off;
  logic          hit;
  // Full-width distance, so an address below the base never aliases into the window
  assign rel = BUS.addr - WIN_BASE;
  assign off = rel[7:0];
  assign hit = CE && WIN_SELECT && (rel < 256);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  read_answer_a: assert property (hit && BUS.rd |=> RVALID)
    else $error("read not answered next cycle");
  // A frozen clock enable holds the last answer, so only enabled idle cycles count
  no_stray_answer_a: assert property (CE && !(hit && BUS.rd) |=> !RVALID)
    else $error("answer without a read");
  a_out_load_a: assert property (hit && BUS.wr && off == mrd_pkg::OFF_A_OUT |=>
    PORT_CFG[mrd_pkg::PORT_A].out_value == $past(BUS.wdata)) else $error("port A out not loaded");
  c_dir_load_a: assert property (hit && BUS.wr && off == mrd_pkg::OFF_C_DIR |=>
    PORT_CFG[mrd_pkg::PORT_C].direction == $past(BUS.wdata)) else $error("port C dir not loaded");
  d_drive_load_a: assert property (hit && BUS.wr && off == mrd_pkg::OFF_D_DRV |=>
    PORT_CFG[mrd_pkg::PORT_D].drive_type == $past(BUS.wdata)) else $error("port D drive wrong");
  map_load_a: assert property (hit && BUS.wr && off == mrd_pkg::OFF_MAP |=>
    SPACE_MAP == $past(BUS.wdata)) else $error("space map not loaded");
  ab_cell_load_a: assert property (|OMC_LOAD[7:0] |->
    $past(hit && BUS.wr && off == mrd_pkg::OFF_OMC_AB) && OMC_DATA[7:0] == $past(BUS.wdata))
    else $error("AB cell load without its write");
  bc_cell_load_a: assert property (|OMC_LOAD[15:8] |->
    $past(hit && BUS.wr && off == mrd_pkg::OFF_OMC_BC) && OMC_DATA[15:8] == $past(BUS.wdata))
    else $error("BC cell load without its write");
  flash_grant_a: assert property (CE && PROC_FLASH_REQ |=>
    FLASH_PROG_GRANT == !$past(TEST_PORT_ACTIVE)) else $error("flash grant wrong");
  no_array_grant_a: assert property (PROC_ARRAY_REQ |-> ##1 !ARRAY_PROG_GRANT)
    else $error("array grant to processor");
  unused_zero_a: assert property (hit && BUS.rd && off inside {8'h30, 8'hFF} |=>
    RDATA == 8'h00) else $error("unused offset not zero");
endmodule : mrd_regs_props
bind mrd_regs mrd_regs_props #(.AW(AW), .DW(DW)) mrd_regs_props_i (.CLOCK, .NRST, .CE, .BUS,
  .WIN_BASE, .WIN_SELECT, .RDATA, .RVALID, .OMC_LOAD, .OMC_DATA, .PORT_CFG, .SPACE_MAP,
  .TEST_PORT_ACTIVE, .PROC_FLASH_REQ, .PROC_ARRAY_REQ, .FLASH_PROG_GRANT, .ARRAY_PROG_GRANT);
`default_nettype wire

// ===== tb/mrd_cpu.sv
// Processor model: one-cycle read and write strobes toward the register window
`default_nettype none
module mrd_cpu (
  // Clock
  input  wire logic             clk,
  // Bus toward the window
  output var mrd_pkg::mrd_bus_t bus,
  output var logic              win_sel,
  input  wire logic [7:0]       rdata,
  input  wire logic             rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    bus = '0;
    win_sel = 1'b0;
  end
  // Released address and data lines invert and the strobes drop, so a design reading a stale value cannot pass by luck
  task automatic drop();
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    bus.addr = ~bus.addr;
    bus.wdata = ~bus.wdata;
    win_sel = 1'b0;
  endtask : drop
  // Flash update code placement is software's concern; only plain strobes here
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s);
    @(posedge clk);
    #1;
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    win_sel = s;
    @(posedge clk);
    #1;
    drop();
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1;
    bus.rd = 1'b1;
    bus.addr = a;
    win_sel = 1'b1;
    @(posedge clk);
    #1;
    ok = rvalid;
    d = rdata;
    drop();
  endtask : rd
endmodule : mrd_cpu
`default_nettype wire

// ===== tb/mrd_regs_bench.sv
// Bench: window decode, port registers, cell masking, protection status and grants
`default_nettype none
module mrd_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RW_OFF [20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hE0, 8'hE2};
  localparam logic [7:0] RO_OFF [11] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0C, 8'h0D, 8'h1A,
    8'h1B, 8'h0A, 8'h0B, 8'h18};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [15:0] base = 16'h4300;
  logic [31:0] pin_in = 32'h8C4A2E71;
  logic [31:0] drv_en = 32'h0F1E2D3C;
  logic [23:0] imc = 24'h5A6B7C;
  logic [15:0] omc_in = 16'hB4D2;
  logic [7:0] main_lk = 8'h96;
  logic [7:0] boot_lk = 8'h69;
  logic tp = 1'b0;
  logic freq = 1'b0;
  logic areq = 1'b0;
  mrd_pkg::mrd_bus_t bus;
  mrd_pkg::mrd_port_cfg_t [mrd_pkg::NPORT-1:0] port_cfg;
  logic win_sel, rvalid, fgrant, agrant;
  logic [7:0] rdata, pwr1, pwr2, page, smap;
  logic [15:0] omc_load, omc_data, port_mode;
  logic [7:0] ro_exp [11];
  int n_fail = 0;
  int checks = 0;
  always #5 clock = ~clock;
  mrd_cpu mrd_cpu_i (.clk(clock), .bus(bus), .win_sel(win_sel), .rdata(rdata), .rvalid(rvalid));
  mrd_regs mrd_regs_i (.CLOCK(clock), .NRST(nrst), .CE(ce), .BUS(bus), .WIN_BASE(base),
    .WIN_SELECT(win_sel), .RDATA(rdata), .RVALID(rvalid), .PIN_IN(pin_in), .DRIVER_EN(drv_en),
    .IMC_IN(imc), .OMC_IN(omc_in), .OMC_LOAD(omc_load), .OMC_DATA(omc_data),
    .PORT_CFG(port_cfg), .PORT_MODE(port_mode), .MAIN_LOCK(main_lk), .BOOT_LOCK(boot_lk),
    .PWR_FIRST(pwr1), .PWR_SECOND(pwr2), .PAGE(page), .SPACE_MAP(smap),
    .TEST_PORT_ACTIVE(tp), .PROC_FLASH_REQ(freq), .PROC_ARRAY_REQ(areq),
    .FLASH_PROG_GRANT(fgrant), .ARRAY_PROG_GRANT(agrant));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    mrd_cpu_i.wr(base + {8'h00, o}, d, 1'b1);
  endtask : wr
  task automatic rchk(input logic [7:0] o, input logic [7:0] e, input string m);
    logic [7:0] d;
    logic ok;
    mrd_cpu_i.rd(base + {8'h00, o}, d, ok);
    chk(ok, 1'b1, "read answer");
    chk(d, e, m);
  endtask : rchk
  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial
  begin
    repeat (8) @(posedge clock);
    #1 nrst = 1'b1;
    foreach (RW_OFF[i]) rchk(RW_OFF[i], 8'h00, "reset value");
    foreach (RW_OFF[i]) wr(RW_OFF[i], RW_OFF[i] ^ 8'hA5);
    foreach (RW_OFF[i]) rchk(RW_OFF[i], RW_OFF[i] ^ 8'hA5, "readback");
    chk(port_cfg[0].out_value, 8'h04 ^ 8'hA5, "A out");
    chk(port_cfg[2].direction, 8'h14 ^ 8'hA5, "C dir");
    chk(port_cfg[3].drive_type, 8'h17 ^ 8'hA5, "D drive");
    chk(port_mode, {8'h03 ^ 8'hA5, 8'h02 ^ 8'hA5}, "mode");
    chk({pwr2, pwr1}, {8'hB4 ^ 8'hA5, 8'hB0 ^ 8'hA5}, "power");
    chk(smap, 8'hE2 ^ 8'hA5, "space map");
    ro_exp = '{pin_in[7:0], pin_in[15:8], pin_in[23:16], pin_in[31:24], drv_en[7:0],
      drv_en[15:8], drv_en[23:16], drv_en[31:24], imc[7:0], imc[15:8], imc[23:16]};
    foreach (RO_OFF[i])
    begin
      wr(RO_OFF[i], ~ro_exp[i]);
      rchk(RO_OFF[i], ro_exp[i], "read-only");
    end
    pin_in[7:0] = 8'h3D;
    repeat (6) @(posedge clock);
    rchk(8'h00, 8'h3D, "live pins");
    rchk(8'h20, omc_in[7:0], "AB cells");
    rchk(8'h21, omc_in[15:8], "BC cells");
    wr(8'h22, 8'h0F);
    wr(8'h20, 8'h5A);
    chk(omc_load[7:0], 8'hF0, "AB masked load");
    chk(omc_data[7:0], 8'h5A, "AB data");
    @(posedge clock);
    #1 chk(omc_load, 16'h0000, "load one cycle");
    wr(8'h23, 8'h3C);
    wr(8'h21, 8'hC3);
    chk(omc_load, 16'hC300, "BC masked load");
    chk(omc_data[15:8], 8'hC3, "BC data");
    wr(8'h22, 8'hFF);
    wr(8'h20, 8'h11);
    chk(omc_load, 16'h0000, "full mask");
    wr(8'hC0, 8'hFF);
    wr(8'hC2, 8'h00);
    rchk(8'hC0, main_lk, "main locks");
    rchk(8'hC2, boot_lk, "boot locks");
    wr(8'h30, 8'h77);
    rchk(8'h30, 8'h00, "unused");
    rchk(8'hFF, 8'h00, "unused top");
    mrd_cpu_i.wr(base + 16'h01E0, 8'h77, 1'b1);
    mrd_cpu_i.wr(base + 16'h00E0, 8'h77, 1'b0);
    ce = 1'b0;
    wr(8'hE0, 8'h77);
    ce = 1'b1;
    chk(page, 8'hE0 ^ 8'hA5, "page guarded");
    base = 16'hA000;
    wr(8'hE0, 8'h3C);
    chk(page, 8'h3C, "new base");
    // Array request is raised with the test port idle, and still no processor array grant is expected
    freq = 1'b1;
    areq = 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({fgrant, agrant}, 2'b10, "flash grant only");
    tp = 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({fgrant, agrant}, 2'b00, "test port owns");
    nrst = 1'b0;
    #1 chk({page, smap, port_mode}, 32'h0, "reset clears");
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    rchk(8'hE2, 8'h00, "after reset");
    results();
  end
endmodule : mrd_regs_bench
`default_nettype wire
